//--- design/analog_comparator_control.sv
// Control, result and interrupt logic for one analog comparator.
// Assumes an AXI4-Lite master, a 16 kHz tick pulse and a stop flag.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "cmp_ctrl_map.svh"
module analog_comparator_control (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cmp_out,
    input  wire logic        tick_16k,
    input  wire logic        stop_mode,
    output logic             cmp_power_on,
    output logic             cmp_irq
);
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    logic       cmp_on_bit;
    logic       cmp_result_flag;
    logic       sample_select;
    logic [1:0] edge_sel;
    logic       irq_status;
    logic       irq_mask;

    logic       have_aw;
    logic       have_w;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       wr_fire;
    logic       wr_known;

    logic       cmp_synced;
    logic       sampled;
    logic       live_level;
    logic       edge_hit;
    logic       sample_now;

    cmp_ctrl_pkg::rd_state_e rd_state;

    // Comparator output resynchronised before any use
    cmp_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (cmp_out),
        .sync_out (cmp_synced)
    );

    // Tick halts in stop mode, so sampling is gated here too
    assign sample_now = tick_16k & ~stop_mode;          // RL8

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sampled <= 1'b0;
        end else if (cmp_on_bit && sample_now) begin
            sampled <= cmp_synced;                      // RL10
        end
    end

    assign live_level = sample_select ? sampled : cmp_synced;  // RL5 RL10

    // Result tracks only while on; holds the last value when off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_result_flag <= 1'b0;
        end else if (cmp_on_bit) begin
            cmp_result_flag <= live_level;              // RL1
        end
    end                                                 // RL3

    cmp_edge_detect u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .level_in (cmp_result_flag),
        .mode     (edge_sel),
        .edge_hit (edge_hit)
    );

    assign cmp_power_on = cmp_on_bit;                   // RL2

    // Write channel: address and data accepted in either order
    assign s_axi_awready = ~have_aw & ~s_axi_bvalid;
    assign s_axi_wready  = ~have_w & ~s_axi_bvalid;
    assign wr_fire       = have_aw & have_w & ~s_axi_bvalid;
    assign wr_known      = (aw_addr == `OFS_ENABLE_RESULT) ||
                           (aw_addr == `OFS_IRQ_CONFIG) ||
                           (aw_addr == `OFS_IRQ_STATUS) ||
                           (aw_addr == `OFS_IRQ_MASK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            have_aw <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            have_aw <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_w <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            have_w <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            have_w <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_on_bit <= 1'b0;
        end else if (wr_fire && w_strb[0] &&
                     aw_addr == `OFS_ENABLE_RESULT) begin
            cmp_on_bit <= w_data[`BIT_ON];              // RL2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_select <= 1'b0;
            edge_sel      <= 2'b00;
        end else if (wr_fire && w_strb[0] &&
                     aw_addr == `OFS_IRQ_CONFIG) begin
            sample_select <= w_data[`BIT_SAMPLE];       // RL5
            edge_sel      <= w_data[`BIT_EDGE_HI:`BIT_EDGE_LO];  // RL6
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= 1'b0;
        end else if (wr_fire && w_strb[0] &&
                     aw_addr == `OFS_IRQ_MASK) begin
            irq_mask <= w_data[0];
        end
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 1'b0;
        end else if (edge_hit) begin
            irq_status <= 1'b1;                         // RL7
        end else if (wr_fire && w_strb[0] && w_data[0] &&
                     aw_addr == `OFS_IRQ_STATUS) begin
            irq_status <= 1'b0;
        end
    end

    assign cmp_irq = irq_status & irq_mask;             // RL7

    // Read channel
    assign s_axi_arready = (rd_state == cmp_ctrl_pkg::RD_IDLE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state    <= cmp_ctrl_pkg::RD_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            unique case (rd_state)
                cmp_ctrl_pkg::RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rd_state    <= cmp_ctrl_pkg::RD_RESP;
                        s_axi_rresp <= RESP_OKAY;
                        unique case (s_axi_araddr)
                            `OFS_ENABLE_RESULT: s_axi_rdata <=
                                {30'h0, cmp_result_flag, cmp_on_bit};  // RL1
                            `OFS_IRQ_CONFIG: s_axi_rdata <=
                                {29'h0, sample_select, edge_sel};
                            `OFS_IRQ_STATUS: s_axi_rdata <=
                                {31'h0, irq_status};
                            `OFS_IRQ_MASK: s_axi_rdata <=
                                {31'h0, irq_mask};
                            default: begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= RESP_SLVERR;
                            end
                        endcase
                    end
                end
                cmp_ctrl_pkg::RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state <= cmp_ctrl_pkg::RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign s_axi_rvalid = (rd_state == cmp_ctrl_pkg::RD_RESP);

    // Settling wait of SETTLE_CYCLES is left to software
    logic unused;
    assign unused = ^{s_axi_awprot, s_axi_arprot, w_strb[3:1],
                      w_data[31:3]};
endmodule : analog_comparator_control

//--- design/cmp_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts
// for the analog comparator control block.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
// Behaviour
// RL1 - Result flag bit 1: plus above minus
// RL2 - Enable bit 0 switches comparator on
// RL3 - Clearing enable freezes the result flag
// RL4 - Software waits 100 us before reading
// RL5 - Bit 2 selects sampling on 16k tick
// RL6 - Edge field: off, fall, rise, both
// RL7 - Matching result edge raises interrupt request
// RL8 - No sampling while in stop mode
// RL9 - Software order: pins, mode, enable, read
// RL10 - Sampled register or synchroniser before edge detect
`ifndef CMP_CTRL_MAP_SVH
`define CMP_CTRL_MAP_SVH

`define OFS_ENABLE_RESULT   8'h00
`define OFS_IRQ_CONFIG      8'h04
`define OFS_IRQ_STATUS      8'h08
`define OFS_IRQ_MASK        8'h0c

`define BIT_ON              0
`define BIT_RESULT          1
`define BIT_SAMPLE          2
`define BIT_EDGE_LO         0
`define BIT_EDGE_HI         1

`define RST_ENABLE_RESULT   8'h00
`define RST_IRQ_CONFIG      8'h00

`define SETTLE_US           100
`define CLK_MHZ             200
`define SETTLE_CYCLES       (`SETTLE_US * `CLK_MHZ)

`endif

//--- design/cmp_ctrl_pkg.sv
// Types shared by the analog comparator control files.
// Assumes the map header carries the offsets, field positions, reset values and timing counts.
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_e;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_RESP
    } rd_state_e;
endpackage : cmp_ctrl_pkg

//--- design/cmp_edge_detect.sv
// Edge detector that raises a one-cycle event for the chosen edge mode.
// Assumes level_in is synchronous to aclk.
`timescale 1ns/10ps
module cmp_edge_detect (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       level_in,
    input  wire logic [1:0] mode,
    output logic            edge_hit
);
    logic prev;
    logic rise;
    logic fall;

    assign rise = level_in & ~prev;
    assign fall = ~level_in & prev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b0;
        end else begin
            prev <= level_in;
        end
    end

    always_comb begin
        unique case (cmp_ctrl_pkg::edge_mode_e'(mode))
            cmp_ctrl_pkg::EDGE_NONE: edge_hit = 1'b0;          // RL6
            cmp_ctrl_pkg::EDGE_FALL: edge_hit = fall;          // RL6
            cmp_ctrl_pkg::EDGE_RISE: edge_hit = rise;          // RL6
            cmp_ctrl_pkg::EDGE_BOTH: edge_hit = rise | fall;   // RL6
        endcase
    end
endmodule : cmp_edge_detect

//--- design/cmp_sync.sv
// Two-flop synchroniser for the comparator output.
// Assumes the analog output is asynchronous to aclk.
`timescale 1ns/10ps
module cmp_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : cmp_sync

//--- dv/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block.
// Assumes the map header on the include path.
`timescale 1ns/10ps
`include "cmp_ctrl_map.svh"
module analog_comparator_control_tb;
    localparam int TD = 40;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        stop_mode = 1'b0;
    logic [11:0] plus_input = 12'h000;
    logic [11:0] minus_input = 12'h000;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, cmp_out, tick_16k;
    logic        cmp_power_on, cmp_irq;
    logic [33:0] exp_q[$];
    int          err_count = 0;
    int          checks = 0;
    always #2.5 aclk = ~aclk;
    analog_comparator_control u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cmp_out, .tick_16k, .stop_mode, .cmp_power_on, .cmp_irq);
    cmp_analog_model #(.TICK_DIV(TD)) u_model (.aclk, .aresetn,
        .power(cmp_power_on), .plus_input, .minus_input,
        .cmp_out, .tick_16k);
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Answers are taken off at the negedge before their handshake edge
    always @(negedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'b00);
        logic aw_t, w_t, b_t;
        exp_q.push_back({r, 32'h0});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic a_t, r_t;
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            a_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            @(posedge aclk);
            if (a_t) s_axi_arvalid <= 1'b0;
        end while (!r_t);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic drive(input logic hi, input int n);
        logic [11:0] p;
        logic [11:0] d;
        p = 12'h400 + 12'($urandom % 512);
        d = 12'h001 + 12'($urandom % 256);
        @(posedge aclk);
        plus_input <= p;
        minus_input <= hi ? p - d : p + d;
        repeat (n) @(posedge aclk);
    endtask : drive
    task automatic pin_is(input logic e, input logic irq);
        @(negedge aclk);
        chk(irq ? cmp_irq : cmp_power_on, e);
    endtask : pin_is
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        #200000;
        err_count++;
        wrap_up();
    end
    initial begin
        void'($urandom(28908));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_ENABLE_RESULT, 34'h0);
        rd(`OFS_IRQ_CONFIG, 34'h0);
        rd(8'h10, {2'b10, 32'h0});
        wr(8'h10, 32'h1, 2'b10);
        drive(1'b1, 2);
        wr(`OFS_IRQ_CONFIG, 32'h3);
        wr(`OFS_IRQ_MASK, 32'h1);
        wr(`OFS_ENABLE_RESULT, 32'h1);
        pin_is(1'b1, 1'b0);
        repeat (`SETTLE_CYCLES) @(posedge aclk);
        rd(`OFS_ENABLE_RESULT, 34'h3);
        rd(`OFS_IRQ_STATUS, 34'h1);
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_IRQ_CONFIG, 32'(m));
            wr(`OFS_IRQ_STATUS, 32'h1);
            drive(1'b0, 10);
            rd(`OFS_IRQ_STATUS, {33'h0, m[0]});
            wr(`OFS_IRQ_STATUS, 32'h1);
            drive(1'b1, 10);
            rd(`OFS_IRQ_STATUS, {33'h0, m[1]});
            pin_is(m[1], 1'b1);
        end
        wr(`OFS_IRQ_MASK, 32'h0);
        pin_is(1'b0, 1'b1);
        wr(`OFS_IRQ_CONFIG, 32'h6);
        drive(1'b0, 3 * TD);
        wr(`OFS_IRQ_STATUS, 32'h1);
        stop_mode <= 1'b1;
        drive(1'b1, 3 * TD);
        rd(`OFS_IRQ_STATUS, 34'h0);
        rd(`OFS_ENABLE_RESULT, 34'h1);
        stop_mode <= 1'b0;
        repeat (3 * TD) @(posedge aclk);
        rd(`OFS_IRQ_STATUS, 34'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        drive(1'b0, 3 * TD);
        wr(`OFS_IRQ_STATUS, 32'h1);
        // Change right after a tick must wait for the next one
        @(posedge tick_16k);
        drive(1'b1, 10);
        rd(`OFS_IRQ_STATUS, 34'h0);
        repeat (TD) @(posedge aclk);
        rd(`OFS_IRQ_STATUS, 34'h1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        wr(`OFS_ENABLE_RESULT, 32'h0);
        drive(1'b0, 3 * TD);
        rd(`OFS_ENABLE_RESULT, 34'h2);
        rd(`OFS_IRQ_STATUS, 34'h0);
        pin_is(1'b0, 1'b0);
        wrap_up();
    end
endmodule : analog_comparator_control_tb

//--- dv/cmp_analog_model.sv
// Comparator front end and slow time base tick for the bench.
// Assumes the bench sets both input levels.
`timescale 1ns/10ps
module cmp_analog_model #(
    parameter int TICK_DIV = 40
) (
    input  logic        aclk,
    input  logic        aresetn,
    input  logic        power,
    input  logic [11:0] plus_input,
    input  logic [11:0] minus_input,
    output logic        cmp_out,
    output logic        tick_16k
);
    int cnt;
    // Tick runs on in stop mode so the block's own gating is what is tested
    always_ff @(posedge aclk) begin
        if (!aresetn || cnt == TICK_DIV - 1) cnt <= 0;
        else cnt <= cnt + 1;
    end
    assign tick_16k = cnt == TICK_DIV - 1;
    // Unpowered output means nothing, so it toggles
    always_ff @(posedge aclk) begin
        if (!aresetn) cmp_out <= 1'b0;
        else if (power) cmp_out <= plus_input > minus_input;
        else cmp_out <= !cmp_out;
    end
endmodule : cmp_analog_model

//--- dv/cmp_ctrl_properties.sv
// Handshake and interrupt properties of the comparator control block.
// Assumes it is bound onto analog_comparator_control.
`timescale 1ns/10ps
module cmp_ctrl_properties (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        cmp_power_on,
    input logic        cmp_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    power_by_write_a: assert property (
        $changed(cmp_power_on) |-> $rose(s_axi_bvalid)) else $error("power");
    irq_clear_write_a: assert property (
        $fell(cmp_irq) |-> $rose(s_axi_bvalid)) else $error("irq fell");
    write_answer_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> ##1 s_axi_bvalid) else $error("no write answer");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read");
    resp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("r drop");
    resp_once_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b twice");
    refuse_busy_a: assert property (
        s_axi_bvalid || s_axi_rvalid |-> !(s_axi_awready && s_axi_arready))
        else $error("ready while busy");
endmodule : cmp_ctrl_properties

bind analog_comparator_control cmp_ctrl_properties u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .cmp_power_on, .cmp_irq);
